// ==== iosr_pkg.sv ====
// What this block does
// - core logic runs straight off the crystal clock, no divider
// - one cycle: read two working registers, compute, write result back
// - status at 3f, external irq mask at 3b, timer irq mask at 39
// - timer irq flags at 38, general control at 35, counter control 33
// - counter value at 32, watchdog control at 21
// - nv store address 1e, data 1d, control 1c
// - port b output 18, direction 17, input pins 16
// - port d output 12, direction 11, input pins 10
// - comparator control and status at 08
// - peripheral registers reached by port load and port store, 00 to 1f also by bit ops
// - bit set and clear only for locations 00 to 1f
// - bit skip tests read the selected bit of locations 00 to 1f
// - flags clear on written one; bit set or clear rewrites whole register
// - status bit 7 gates every interrupt
// - taking an interrupt clears bit 7, interrupt return sets it
// - status bit 6 is the bit copy holder for store and load
// - status bit 5 is the low nibble half carry
// - status bit 4 always equals negative xor overflow
// - bit 3 is overflow, bit 2 is negative result
// - bit 1 set on zero result
// - bit 0 is carry; status not saved on interrupt entry
// - 64 io locations chosen by a 6-bit address
package iosr_pkg;
   // io map
   localparam logic [5:0] A_STAT  = 6'h3f;
   localparam logic [5:0] A_EMSK  = 6'h3b;
   localparam logic [5:0] A_TMSK  = 6'h39;
   localparam logic [5:0] A_TFLG  = 6'h38;
   localparam logic [5:0] A_GCTL  = 6'h35;
   localparam logic [5:0] A_CCTL  = 6'h33;
   localparam logic [5:0] A_CVAL  = 6'h32;
   localparam logic [5:0] A_WDOG  = 6'h21;
   localparam logic [5:0] A_NVAD  = 6'h1e;
   localparam logic [5:0] A_NVDT  = 6'h1d;
   localparam logic [5:0] A_NVCT  = 6'h1c;
   localparam logic [5:0] A_PBOUT = 6'h18;
   localparam logic [5:0] A_PBDIR = 6'h17;
   localparam logic [5:0] A_PBIN  = 6'h16;
   localparam logic [5:0] A_PDOUT = 6'h12;
   localparam logic [5:0] A_PDDIR = 6'h11;
   localparam logic [5:0] A_PDIN  = 6'h10;
   localparam logic [5:0] A_ACMP  = 6'h08;
   localparam logic [7:0] IO_RST  = 8'h00;
   // status bit positions
   localparam int B_I = 7;
   localparam int B_T = 6;
   localparam int B_H = 5;
   localparam int B_S = 4;
   localparam int B_V = 3;
   localparam int B_N = 2;
   localparam int B_Z = 1;
   localparam int B_C = 0;
   // operation codes
   localparam logic [3:0] OP_NOP  = 4'h0;
   localparam logic [3:0] OP_ADD  = 4'h1;
   localparam logic [3:0] OP_SUB  = 4'h2;
   localparam logic [3:0] OP_AND  = 4'h3;
   localparam logic [3:0] OP_OR   = 4'h4;
   localparam logic [3:0] OP_EOR  = 4'h5;
   localparam logic [3:0] OP_IN   = 4'h6;
   localparam logic [3:0] OP_OUT  = 4'h7;
   localparam logic [3:0] OP_SETB = 4'h8;
   localparam logic [3:0] OP_CLRB = 4'h9;
   localparam logic [3:0] OP_SKBS = 4'ha;
   localparam logic [3:0] OP_SKBC = 4'hb;
   localparam logic [3:0] OP_TSTO = 4'hc;
   localparam logic [3:0] OP_TLOD = 4'hd;
   localparam logic [3:0] OP_IRET = 4'he;
endpackage

// ==== iosr_core.sv ====
`timescale 1ns/1ps
module iosr_core (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // instruction from decode
   input  wire logic [3:0] op,
   input  wire logic [4:0] dst_sel,
   input  wire logic [4:0] src_sel,
   input  wire logic [5:0] io_addr,
   input  wire logic [2:0] bit_sel,
   // events and pins
   input  wire logic       irq_req,
   input  wire logic [7:0] timer_flag_set,
   input  wire logic [7:0] port_b_pins,
   input  wire logic [7:0] port_d_pins,
   // core results
   output logic            skip_q,
   output logic            irq_take_q,
   output logic [7:0]      status_flags_q,
   // peripheral registers
   output logic [7:0]      ext_irq_mask_q,
   output logic [7:0]      timer_irq_mask_q,
   output logic [7:0]      timer_irq_flags_q,
   output logic [7:0]      general_control_q,
   output logic [7:0]      counter_control_q,
   output logic [7:0]      counter_value_q,
   output logic [7:0]      watchdog_control_q,
   output logic [7:0]      nv_store_address_q,
   output logic [7:0]      nv_store_data_q,
   output logic [7:0]      nv_store_control_q,
   output logic [7:0]      port_b_output_q,
   output logic [7:0]      port_b_direction_q,
   output logic [7:0]      port_d_output_q,
   output logic [7:0]      port_d_direction_q,
   output logic [7:0]      comparator_ctrl_status_q
);

   // mclk drives every flop directly; no prescaler in this path

   // storage locations, pins excluded
   function automatic logic is_rw(input logic [5:0] a);
      case (a)
         iosr_pkg::A_STAT, iosr_pkg::A_EMSK, iosr_pkg::A_TMSK,
         iosr_pkg::A_TFLG, iosr_pkg::A_GCTL, iosr_pkg::A_CCTL,
         iosr_pkg::A_CVAL, iosr_pkg::A_WDOG, iosr_pkg::A_NVAD,
         iosr_pkg::A_NVDT, iosr_pkg::A_NVCT, iosr_pkg::A_PBOUT,
         iosr_pkg::A_PBDIR, iosr_pkg::A_PDOUT, iosr_pkg::A_PDDIR,
         iosr_pkg::A_ACMP: is_rw = 1'b1;
         default:          is_rw = 1'b0;
      endcase
   endfunction

   logic [7:0] rf_q [0:31];
   logic [7:0] io_q [0:63];
   logic [7:0] rd_a;
   logic [7:0] rd_b;
   logic [7:0] io_rdata;
   logic [7:0] io_wdata;
   logic [7:0] bit_mask;
   logic       bit_low;
   logic       io_wr_en;
   logic [7:0] alu_res;
   logic       alu_c;
   logic       alu_h;
   logic       alu_v;
   logic       alu_op;
   logic       arith_op;
   logic [7:0] rf_wdata;
   logic       rf_we;
   logic [7:0] stat_d;
   logic [7:0] tflg_d;
   logic       irq_take_d;
   logic       skip_d;

   // two operand reads feeding the same-cycle result
   assign rd_a     = rf_q[dst_sel];
   assign rd_b     = rf_q[src_sel];
   assign bit_mask = 8'h01 << bit_sel;
   assign bit_low  = (io_addr[5] == 1'b0);

   // io read mux; pins are live, unused reads as zero
   always_comb begin
      io_rdata = 8'h00;
      if (is_rw(io_addr)) begin
         io_rdata = io_q[io_addr];
      end else if (io_addr == iosr_pkg::A_PBIN) begin
         io_rdata = port_b_pins;
      end else if (io_addr == iosr_pkg::A_PDIN) begin
         io_rdata = port_d_pins;
      end
   end

   // only port store and in-range bit ops write io
   assign io_wr_en = (op == iosr_pkg::OP_OUT) ||
                     (((op == iosr_pkg::OP_SETB) || (op == iosr_pkg::OP_CLRB))
                      && bit_low);

   // bit ops rewrite the whole byte as read
   always_comb begin
      if (op == iosr_pkg::OP_OUT) begin
         io_wdata = rd_a;
      end else if (op == iosr_pkg::OP_SETB) begin
         io_wdata = io_rdata | bit_mask;
      end else begin
         io_wdata = io_rdata & ~bit_mask;
      end
   end

   // alu, single cycle
   always_comb begin
      logic [8:0] w;
      w        = 9'h000;
      alu_res  = 8'h00;
      alu_c    = io_q[iosr_pkg::A_STAT][iosr_pkg::B_C];
      alu_h    = io_q[iosr_pkg::A_STAT][iosr_pkg::B_H];
      alu_v    = 1'b0;
      arith_op = 1'b0;
      alu_op   = 1'b1;
      case (op)
         iosr_pkg::OP_ADD: begin
            w        = {1'b0, rd_a} + {1'b0, rd_b};
            alu_res  = w[7:0];
            alu_c    = w[8];
            alu_h    = (rd_a[3] & rd_b[3]) | (rd_b[3] & ~w[3])
                     | (~w[3] & rd_a[3]);
            alu_v    = (rd_a[7] & rd_b[7] & ~w[7])
                     | (~rd_a[7] & ~rd_b[7] & w[7]);
            arith_op = 1'b1;
         end
         iosr_pkg::OP_SUB: begin
            w        = {1'b0, rd_a} - {1'b0, rd_b};
            alu_res  = w[7:0];
            alu_c    = w[8];
            alu_h    = (~rd_a[3] & rd_b[3]) | (rd_b[3] & w[3])
                     | (w[3] & ~rd_a[3]);
            alu_v    = (rd_a[7] & ~rd_b[7] & ~w[7])
                     | (~rd_a[7] & rd_b[7] & w[7]);
            arith_op = 1'b1;
         end
         iosr_pkg::OP_AND: alu_res = rd_a & rd_b;
         iosr_pkg::OP_OR:  alu_res = rd_a | rd_b;
         iosr_pkg::OP_EOR: alu_res = rd_a ^ rd_b;
         default:          alu_op  = 1'b0;
      endcase
   end

   // write-back select
   always_comb begin
      rf_we    = 1'b1;
      rf_wdata = alu_res;
      if (op == iosr_pkg::OP_IN) begin
         rf_wdata = io_rdata;
      end else if (op == iosr_pkg::OP_TLOD) begin
         rf_wdata = io_q[iosr_pkg::A_STAT][iosr_pkg::B_T] ?
                    (rd_a | bit_mask) : (rd_a & ~bit_mask);
      end else if (!alu_op) begin
         rf_we = 1'b0;
      end
   end

   // interrupt only while the global enable stands
   assign irq_take_d = irq_req && io_q[iosr_pkg::A_STAT][iosr_pkg::B_I];

   // status next value; entry does not stack it, software must
   always_comb begin
      stat_d = io_q[iosr_pkg::A_STAT];
      if ((op == iosr_pkg::OP_OUT) && (io_addr == iosr_pkg::A_STAT)) begin
         stat_d = io_wdata;
      end
      if (alu_op) begin
         stat_d[iosr_pkg::B_C] = alu_c;
         stat_d[iosr_pkg::B_Z] = (alu_res == 8'h00);
         stat_d[iosr_pkg::B_N] = alu_res[7];
         stat_d[iosr_pkg::B_V] = alu_v;
         if (arith_op) begin
            stat_d[iosr_pkg::B_H] = alu_h;
         end
      end
      if (op == iosr_pkg::OP_TSTO) begin
         stat_d[iosr_pkg::B_T] = rd_a[bit_sel];
      end
      if (op == iosr_pkg::OP_IRET) begin
         stat_d[iosr_pkg::B_I] = 1'b1;
      end
      // taking wins over a return in the same cycle
      if (irq_take_d) begin
         stat_d[iosr_pkg::B_I] = 1'b0;
      end
      // stored, so a software write cannot break the relation
      stat_d[iosr_pkg::B_S] = stat_d[iosr_pkg::B_N]
                            ^ stat_d[iosr_pkg::B_V];
   end

   // write-one clears; a new event in the same cycle wins
   always_comb begin
      tflg_d = io_q[iosr_pkg::A_TFLG];
      if (io_wr_en && (io_addr == iosr_pkg::A_TFLG)) begin
         tflg_d = tflg_d & ~io_wdata;
      end
      tflg_d = tflg_d | timer_flag_set;
   end

   // skip decision, lower half only
   always_comb begin
      skip_d = 1'b0;
      if (bit_low && (op == iosr_pkg::OP_SKBS)) begin
         skip_d = io_rdata[bit_sel];
      end else if (bit_low && (op == iosr_pkg::OP_SKBC)) begin
         skip_d = ~io_rdata[bit_sel];
      end
   end

   // working registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            rf_q[i] <= 8'h00;
         end
      end else if (rf_we) begin
         rf_q[dst_sel] <= rf_wdata;
      end
   end

   // io register file; reserved and pin locations never stored
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < 64; i++) begin
            io_q[i] <= iosr_pkg::IO_RST;
         end
      end else begin
         if (io_wr_en && is_rw(io_addr) && (io_addr != iosr_pkg::A_STAT)
             && (io_addr != iosr_pkg::A_TFLG)) begin
            io_q[io_addr] <= io_wdata;
         end
         io_q[iosr_pkg::A_TFLG] <= tflg_d;
         io_q[iosr_pkg::A_STAT] <= stat_d;
      end
   end

   // one-cycle results
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         skip_q     <= 1'b0;
         irq_take_q <= 1'b0;
      end else begin
         skip_q     <= skip_d;
         irq_take_q <= irq_take_d;
      end
   end

   // fixed placement of each register
   assign status_flags_q           = io_q[iosr_pkg::A_STAT];
   assign ext_irq_mask_q           = io_q[iosr_pkg::A_EMSK];
   assign timer_irq_mask_q         = io_q[iosr_pkg::A_TMSK];
   assign timer_irq_flags_q        = io_q[iosr_pkg::A_TFLG];
   assign general_control_q        = io_q[iosr_pkg::A_GCTL];
   assign counter_control_q        = io_q[iosr_pkg::A_CCTL];
   assign counter_value_q          = io_q[iosr_pkg::A_CVAL];
   assign watchdog_control_q       = io_q[iosr_pkg::A_WDOG];
   assign nv_store_address_q       = io_q[iosr_pkg::A_NVAD];
   assign nv_store_data_q          = io_q[iosr_pkg::A_NVDT];
   assign nv_store_control_q       = io_q[iosr_pkg::A_NVCT];
   assign port_b_output_q          = io_q[iosr_pkg::A_PBOUT];
   assign port_b_direction_q       = io_q[iosr_pkg::A_PBDIR];
   assign port_d_output_q          = io_q[iosr_pkg::A_PDOUT];
   assign port_d_direction_q       = io_q[iosr_pkg::A_PDDIR];
   assign comparator_ctrl_status_q = io_q[iosr_pkg::A_ACMP];

   // checks
   a_sign_relation:
   assert property (@(posedge mclk) disable iff (!rst_n)
      status_flags_q[4] == (status_flags_q[2] ^ status_flags_q[3]))
      else $error("sign bit differs from n xor v");

   a_irq_gate_enable:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (irq_req && !status_flags_q[7]) |=> !irq_take_q)
      else $error("interrupt taken while disabled");

   a_irq_clears_enable:
   assert property (@(posedge mclk) disable iff (!rst_n)
      irq_take_q |-> !status_flags_q[7] ##1 !irq_take_q)
      else $error("enable not cleared on interrupt");

   a_return_sets_enable:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_IRET && !irq_req) |=> status_flags_q[7])
      else $error("return did not set enable");

   a_flag_write_clear:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_OUT && io_addr == iosr_pkg::A_TFLG)
      |=> timer_irq_flags_q == (($past(timer_irq_flags_q) & ~$past(rd_a))
                               | $past(timer_flag_set)))
      else $error("flag write-one clear wrong");

   a_flag_set_wins:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (timer_flag_set != 8'h00)
      |=> (timer_irq_flags_q & $past(timer_flag_set)) == $past(timer_flag_set))
      else $error("timer flag event lost");

   a_skip_upper_none:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (io_addr[5] && (op == iosr_pkg::OP_SKBS || op == iosr_pkg::OP_SKBC))
      |=> !skip_q)
      else $error("bit test above 1f took effect");

   a_bit_set_low:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_SETB && io_addr == iosr_pkg::A_PBDIR)
      |=> port_b_direction_q[$past(bit_sel)])
      else $error("bit set missed low location");

   a_bit_clear_low:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_CLRB && io_addr == iosr_pkg::A_PBDIR)
      |=> !port_b_direction_q[$past(bit_sel)])
      else $error("bit clear missed low location");

   a_bit_upper_none:
   assert property (@(posedge mclk) disable iff (!rst_n)
      ((op == iosr_pkg::OP_SETB || op == iosr_pkg::OP_CLRB) && io_addr == iosr_pkg::A_WDOG)
      |=> watchdog_control_q == $past(watchdog_control_q))
      else $error("bit op above 1f took effect");

   a_skip_bit_test:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_SKBS && io_addr == iosr_pkg::A_PBDIR)
      |=> skip_q == $past(port_b_direction_q[bit_sel]))
      else $error("skip does not follow tested bit");

   a_tbit_store_copy:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_TSTO) |=> status_flags_q[6] == $past(rd_a[bit_sel]))
      else $error("bit store did not reach t");

   a_zero_flag_add:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_ADD) |=> status_flags_q[1] == ($past(8'(rd_a + rd_b)) == 8'h00))
      else $error("zero flag wrong after add");

   a_zero_flag_logic:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_AND || op == iosr_pkg::OP_OR || op == iosr_pkg::OP_EOR)
      |=> status_flags_q[1] == (rf_q[$past(dst_sel)] == 8'h00))
      else $error("zero flag wrong after logic op");

   a_negative_result:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_ADD || op == iosr_pkg::OP_SUB || op == iosr_pkg::OP_AND)
      |=> status_flags_q[2] == rf_q[$past(dst_sel)][7])
      else $error("negative flag differs from result");

   a_half_carry_add:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_ADD)
      |=> status_flags_q[5] == $past(({1'b0, rd_a[3:0]} + {1'b0, rd_b[3:0]}) > 5'h0f))
      else $error("half carry wrong after add");

   a_carry_add:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_ADD)
      |=> status_flags_q[0] == $past(({1'b0, rd_a} + {1'b0, rd_b}) > 9'h0ff))
      else $error("carry wrong after add");

   a_status_store:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_OUT && io_addr == iosr_pkg::A_STAT && !irq_req)
      |=> {status_flags_q[7:5], status_flags_q[3:0]} == $past({rd_a[7:5], rd_a[3:0]}))
      else $error("status write not stored");

   a_port_b_store:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_OUT && io_addr == iosr_pkg::A_PBOUT)
      |=> port_b_output_q == $past(rd_a))
      else $error("port b output not stored");

   a_unused_read_zero:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (op == iosr_pkg::OP_IN && !is_rw(io_addr) && io_addr != iosr_pkg::A_PBIN
       && io_addr != iosr_pkg::A_PDIN) |=> rf_q[$past(dst_sel)] == 8'h00)
      else $error("unused location read nonzero");

endmodule

// ==== iosr_dec.sv ====
`timescale 1ns/1ps
module iosr_dec (
   // clock
   input  wire logic       mclk,
   // answers from core
   input  wire logic       skip_q,
   input  wire logic       irq_take_q,
   // instruction to core
   output logic [3:0]      op,
   output logic [4:0]      dst_sel,
   output logic [4:0]      src_sel,
   output logic [5:0]      io_addr,
   output logic [2:0]      bit_sel
);
   initial begin
      op      = iosr_pkg::OP_NOP;
      dst_sel = 5'h00;
      src_sel = 5'h00;
      io_addr = 6'h00;
      bit_sel = 3'h0;
   end
   // entered at a falling edge; a nop cycle follows so no op is taken twice
   task automatic issue(input logic [3:0] o, input logic [4:0] d, input logic [4:0] r,
                        input logic [5:0] a, input logic [2:0] b,
                        output logic sk, output logic tk);
      op      = o;
      dst_sel = d;
      src_sel = r;
      io_addr = a;
      bit_sel = b;
      @(negedge mclk);
      sk = skip_q;
      tk = irq_take_q;
      op = iosr_pkg::OP_NOP;
      @(negedge mclk);
   endtask
endmodule

// ==== io_space_and_status_register_tb.sv ====
`timescale 1ns/1ps
module io_space_and_status_register_tb;
   logic             mclk;
   logic             rst_n;
   logic             irq_req;
   logic [7:0]       timer_flag_set;
   logic [7:0]       port_b_pins;
   logic [7:0]       port_d_pins;
   logic [3:0]       op;
   logic [4:0]       dst_sel;
   logic [4:0]       src_sel;
   logic [5:0]       io_addr;
   logic [2:0]       bit_sel;
   logic             skip_q;
   logic             irq_take_q;
   logic [7:0]       st;
   logic [7:0]       emsk, tmsk, tflg, gctl, cctl, cval, wdog;
   logic [7:0]       nvad, nvdt, nvct, pbout, pbdir, pdout, pddir, acmp;
   logic [13:0][7:0] regs_w;
   logic             sk;
   logic             tk;
   logic [7:0]       v;
   int               fail_count;
   int               n_compared;
   localparam logic [5:0] ADDR [14] = '{6'h3b, 6'h39, 6'h35, 6'h33, 6'h32, 6'h21, 6'h1e,
                                        6'h1d, 6'h1c, 6'h18, 6'h17, 6'h12, 6'h11, 6'h08};
   assign regs_w = {acmp, pddir, pdout, pbdir, pbout, nvct, nvdt, nvad, wdog, cval, cctl,
                    gctl, tmsk, emsk};

   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   iosr_dec i_dec (.mclk(mclk), .skip_q(skip_q), .irq_take_q(irq_take_q), .op(op),
                   .dst_sel(dst_sel), .src_sel(src_sel), .io_addr(io_addr), .bit_sel(bit_sel));

   iosr_core i_dut (.mclk(mclk), .rst_n(rst_n), .op(op), .dst_sel(dst_sel), .src_sel(src_sel),
      .io_addr(io_addr), .bit_sel(bit_sel), .irq_req(irq_req), .timer_flag_set(timer_flag_set),
      .port_b_pins(port_b_pins), .port_d_pins(port_d_pins), .skip_q(skip_q),
      .irq_take_q(irq_take_q), .status_flags_q(st), .ext_irq_mask_q(emsk),
      .timer_irq_mask_q(tmsk), .timer_irq_flags_q(tflg), .general_control_q(gctl),
      .counter_control_q(cctl), .counter_value_q(cval), .watchdog_control_q(wdog),
      .nv_store_address_q(nvad), .nv_store_data_q(nvdt), .nv_store_control_q(nvct),
      .port_b_output_q(pbout), .port_b_direction_q(pbdir), .port_d_output_q(pdout),
      .port_d_direction_q(pddir), .comparator_ctrl_status_q(acmp));

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic do_op(input logic [3:0] o, input logic [4:0] d, input logic [4:0] r,
                        input logic [5:0] a, input logic [2:0] b);
      i_dec.issue(o, d, r, a, b, sk, tk);
   endtask

   // working registers are loaded through the port b pins, one port load each
   task automatic ld(input logic [4:0] r, input logic [7:0] val);
      port_b_pins = val;
      do_op(iosr_pkg::OP_IN, r, 5'h00, iosr_pkg::A_PBIN, 3'h0);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] val);
      ld(5'h01, val);
      do_op(iosr_pkg::OP_OUT, 5'h01, 5'h00, a, 3'h0);
   endtask

   // readback goes through port d output, so that location is clobbered
   task automatic rd(input logic [5:0] a, output logic [7:0] val);
      do_op(iosr_pkg::OP_IN, 5'h02, 5'h00, a, 3'h0);
      do_op(iosr_pkg::OP_OUT, 5'h02, 5'h00, iosr_pkg::A_PDOUT, 3'h0);
      val = pdout;
   endtask

   task automatic t_reset();
      chk(st, 8'h00);
      chk(tflg, 8'h00);
      for (int i = 0; i < 14; i++) begin
         chk(regs_w[i], 8'h00);
      end
      $display("done reset");
   endtask

   task automatic t_map();
      for (int i = 0; i < 14; i++) begin
         wr(ADDR[i], 8'(i * 17 + 3));
      end
      for (int i = 0; i < 14; i++) begin
         chk(regs_w[i], 8'(i * 17 + 3));
      end
      for (int i = 0; i < 14; i++) begin
         if (i != 11) begin
            rd(ADDR[i], v);
            chk(v, 8'(i * 17 + 3));
         end
      end
      port_d_pins = 8'h5a;
      rd(iosr_pkg::A_PDIN, v);
      chk(v, 8'h5a);
      port_b_pins = 8'ha5;
      rd(iosr_pkg::A_PBIN, v);
      chk(v, 8'ha5);
      $display("done map");
   endtask

   // reserved locations are only read; the read-only pin locations take the writes
   task automatic t_unused();
      wr(iosr_pkg::A_PDIN, 8'hff);
      wr(iosr_pkg::A_PBIN, 8'hff);
      rd(6'h05, v);
      chk(v, 8'h00);
      rd(6'h3e, v);
      chk(v, 8'h00);
      rd(iosr_pkg::A_PDIN, v);
      chk(v, 8'h5a);
      for (int i = 0; i < 14; i++) begin
         if (i != 11) begin
            chk(regs_w[i], 8'(i * 17 + 3));
         end
      end
      $display("done unused");
   endtask

   task automatic t_bits();
      wr(iosr_pkg::A_PBDIR, 8'h00);
      do_op(iosr_pkg::OP_SETB, 5'h00, 5'h00, iosr_pkg::A_PBDIR, 3'h3);
      chk(pbdir, 8'h08);
      do_op(iosr_pkg::OP_SETB, 5'h00, 5'h00, iosr_pkg::A_PBDIR, 3'h0);
      do_op(iosr_pkg::OP_CLRB, 5'h00, 5'h00, iosr_pkg::A_PBDIR, 3'h3);
      chk(pbdir, 8'h01);
      do_op(iosr_pkg::OP_SKBS, 5'h00, 5'h00, iosr_pkg::A_PBDIR, 3'h0);
      chk(8'(sk), 8'h01);
      chk(8'(skip_q), 8'h00);
      do_op(iosr_pkg::OP_SKBC, 5'h00, 5'h00, iosr_pkg::A_PBDIR, 3'h0);
      chk(8'(sk), 8'h00);
      do_op(iosr_pkg::OP_SKBC, 5'h00, 5'h00, iosr_pkg::A_PBDIR, 3'h3);
      chk(8'(sk), 8'h01);
      do_op(iosr_pkg::OP_SETB, 5'h00, 5'h00, iosr_pkg::A_WDOG, 3'h0);
      chk(wdog, 8'h58);
      do_op(iosr_pkg::OP_SKBS, 5'h00, 5'h00, iosr_pkg::A_WDOG, 3'h3);
      chk(8'(sk), 8'h00);
      $display("done bits");
   endtask

   task automatic t_alu();
      wr(iosr_pkg::A_STAT, 8'h1c);
      chk(st, 8'h0c);
      wr(iosr_pkg::A_STAT, 8'h00);
      ld(5'h01, 8'h0f);
      ld(5'h02, 8'h01);
      do_op(iosr_pkg::OP_ADD, 5'h01, 5'h02, 6'h00, 3'h0);
      chk(st, 8'h20);
      ld(5'h01, 8'h80);
      ld(5'h02, 8'h80);
      do_op(iosr_pkg::OP_ADD, 5'h01, 5'h02, 6'h00, 3'h0);
      chk(st, 8'h1b);
      do_op(iosr_pkg::OP_AND, 5'h01, 5'h02, 6'h00, 3'h0);
      chk(st, 8'h03);
      ld(5'h04, 8'h00);
      ld(5'h05, 8'h01);
      do_op(iosr_pkg::OP_SUB, 5'h04, 5'h05, 6'h00, 3'h0);
      chk(st, 8'h35);
      do_op(iosr_pkg::OP_OR, 5'h04, 5'h05, 6'h00, 3'h0);
      chk(st, 8'h35);
      do_op(iosr_pkg::OP_EOR, 5'h04, 5'h04, 6'h00, 3'h0);
      chk(st, 8'h23);
      do_op(iosr_pkg::OP_OUT, 5'h04, 5'h00, iosr_pkg::A_PDOUT, 3'h0);
      chk(pdout, 8'h00);
      $display("done alu");
   endtask

   task automatic t_tbit();
      wr(iosr_pkg::A_STAT, 8'h00);
      ld(5'h08, 8'h04);
      do_op(iosr_pkg::OP_TSTO, 5'h08, 5'h00, 6'h00, 3'h2);
      chk(st, 8'h40);
      ld(5'h09, 8'h00);
      do_op(iosr_pkg::OP_TLOD, 5'h09, 5'h00, 6'h00, 3'h5);
      do_op(iosr_pkg::OP_OUT, 5'h09, 5'h00, iosr_pkg::A_PDOUT, 3'h0);
      chk(pdout, 8'h20);
      do_op(iosr_pkg::OP_TSTO, 5'h09, 5'h00, 6'h00, 3'h0);
      chk(st, 8'h00);
      $display("done tbit");
   endtask

   task automatic t_irq();
      irq_req = 1'b1;
      do_op(iosr_pkg::OP_NOP, 5'h00, 5'h00, 6'h00, 3'h0);
      chk(8'(tk), 8'h00);
      irq_req = 1'b0;
      wr(iosr_pkg::A_STAT, 8'h83);
      irq_req = 1'b1;
      do_op(iosr_pkg::OP_NOP, 5'h00, 5'h00, 6'h00, 3'h0);
      irq_req = 1'b0;
      chk(8'(tk), 8'h01);
      chk(8'(irq_take_q), 8'h00);
      chk(st, 8'h03);
      do_op(iosr_pkg::OP_IRET, 5'h00, 5'h00, 6'h00, 3'h0);
      chk(st, 8'h83);
      $display("done irq");
   endtask

   task automatic t_flags();
      timer_flag_set = 8'h05;
      do_op(iosr_pkg::OP_NOP, 5'h00, 5'h00, 6'h00, 3'h0);
      timer_flag_set = 8'h00;
      chk(tflg, 8'h05);
      wr(iosr_pkg::A_TFLG, 8'h01);
      chk(tflg, 8'h04);
      // event only in the clearing cycle, so a lost set cannot be refilled later
      ld(5'h01, 8'h01);
      timer_flag_set = 8'h01;
      fork
         do_op(iosr_pkg::OP_OUT, 5'h01, 5'h00, iosr_pkg::A_TFLG, 3'h0);
         begin
            @(negedge mclk);
            timer_flag_set = 8'h00;
         end
      join
      chk(tflg, 8'h05);
      $display("done flags");
   endtask

   initial begin
      fail_count = 0;
      n_compared = 0;
      rst_n = 1'b0;
      irq_req = 1'b0;
      timer_flag_set = 8'h00;
      port_b_pins = 8'h00;
      port_d_pins = 8'h00;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      t_reset();
      t_map();
      t_unused();
      t_bits();
      t_alu();
      t_tbit();
      t_irq();
      t_flags();
      summarize();
   end

   // whole run is a few hundred cycles; this bound is generous
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      summarize();
   end
endmodule
